// File: hw/frame_prefix_regs.svh
`ifndef FRAME_PREFIX_REGS_SVH
`define FRAME_PREFIX_REGS_SVH

// Register byte offsets
`define OFS_BIT_CLOCK_PRESCALE 12'h114
`define OFS_RADIO_WARMUP_LEAD  12'h118
`define OFS_PREAMBLE_PATTERN   12'h11C
`define OFS_SYNC_WORD_LOW      12'h124
`define OFS_SYNC_WORD_HIGH     12'h128
`define OFS_FRAME_CONTROL      12'h130
`define OFS_FRAME_STATUS       12'h134

// Field positions
`define PRESCALE_MSB     15
`define TX_LEAD_MSB      27
`define TX_LEAD_LSB      16
`define RX_LEAD_MSB      11
`define RX_LEAD_LSB      0
`define CTRL_REPEAT_MSB  3
`define CTRL_REPEAT_LSB  0
`define CTRL_TX_START    4
`define CTRL_RX_START    5
`define CTRL_STD_MODE    6

// Reset values
`define RST_PRESCALE     16'h0000
`define RST_WARMUP       12'h000
`define RST_WORD         32'h0000_0000
`define RST_REPEAT       4'h0

// Word length figures
`define WORD_LAST_BIT    5'h1F
`define STD_HIGH_LAST    5'h07

`endif

// File: hw/frame_prefix_pkg.sv
package frame_prefix_pkg;

    // Sequencer states
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_TX_LEAD,
        ST_TX_PRE,
        ST_TX_SYNC_LO,
        ST_TX_SYNC_HI,
        ST_RX_LEAD
    } seq_state_t;

    typedef logic [15:0] prescale_t;
    typedef logic [11:0] lead_t;

endpackage

// File: hw/bit_tick_if.sv
`timescale 1ns/100ps
interface bit_tick_if;
    import frame_prefix_pkg::*;

    prescale_t divider;
    logic      tick;

    modport ctl (output divider, input  tick);
    modport div (input  divider, output tick);
endinterface

// File: hw/bit_prescaler.sv
`timescale 1ns/100ps
module bit_prescaler #(
    parameter int CW = 16
) (
    // Clock and reset
    input  wire logic ref_clk,
    input  wire logic rst_b,
    // Divider setting and tick
    bit_tick_if.div   tk
);
    import frame_prefix_pkg::*;

    logic [CW-1:0] cnt_q;
    logic [CW-1:0] cnt_d;
    logic          tick_q;
    logic          tick_d;

    // Reload after divider+1 cycles, one tick per reload
    always_comb begin
        if (cnt_q >= tk.divider[CW-1:0]) begin
            cnt_d  = '0;
            tick_d = 1'b1;
        end else begin
            cnt_d  = cnt_q + 1'b1;
            tick_d = 1'b0;
        end
    end

    // Counter runs on the peripheral clock
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            cnt_q  <= '0;
            tick_q <= 1'b0;
        end else begin
            cnt_q  <= cnt_d;
            tick_q <= tick_d;
        end
    end

    assign tk.tick = tick_q;
endmodule

// File: hw/frame_prefix_top.sv
// Function
// - Bit clock is the input clock over the prescale value plus one.
// - The prescaler counts on the peripheral clock.
// - The prescale register is write-only and resets to zero.
// - Tx warmup leads the first preamble bit by the set bit periods.
// - Rx warmup leads the first expected bit by the set bit periods.
// - Warmup bits 31:28 and 15:12 are reserved with no function.
// - A software-written 32-bit pattern is sent as the preamble.
// - The preamble repeats as often as the 4-bit repeat field says.
// - The lower sync word is held and sent before the upper one.
// - The upper sync word follows, only its low 8 bits in std mode.
//
// Design decision made here: the Wishbone slave port.
`timescale 1ns/100ps
`include "frame_prefix_regs.svh"
module frame_prefix_top (
    // Clock and reset
    input  wire logic                     ref_clk,
    input  wire logic                     rst_b,
    // Wishbone slave
    input  wire logic                     wb_cyc_i,
    input  wire logic                     wb_stb_i,
    input  wire logic                     wb_we_i,
    input  wire logic [11:0]              wb_adr_i,
    input  wire logic [3:0]               wb_sel_i,
    input  wire logic [31:0]              wb_dat_i,
    output logic      [31:0]              wb_dat_o,
    output logic                          wb_ack_o,
    // Modem side
    output logic                          tx_warmup,
    output logic                          tx_bit,
    output logic                          tx_bit_stb,
    output logic                          rx_warmup,
    output logic                          rx_expect,
    output frame_prefix_pkg::prescale_t   bit_divider
);
    import frame_prefix_pkg::*;

    bit_tick_if tk ();

    // Register state
    prescale_t   div_q,    div_d;
    lead_t       txl_q,    txl_d;
    lead_t       rxl_q,    rxl_d;
    logic [31:0] pre_q,    pre_d;
    logic [31:0] slo_q,    slo_d;
    logic [31:0] shi_q,    shi_d;
    logic [3:0]  rep_q,    rep_d;
    logic        std_q,    std_d;
    logic        ack_q,    ack_d;
    logic [31:0] rdat_q,   rdat_d;
    logic        go_tx,    go_rx;

    // Sequencer state
    seq_state_t  st_q,     st_d;
    lead_t       lcnt_q,   lcnt_d;
    logic [4:0]  idx_q,    idx_d;
    logic [3:0]  rcnt_q,   rcnt_d;
    logic        txw_q,    txw_d;
    logic        rxw_q,    rxw_d;
    logic        bit_q,    bit_d;
    logic        stb_q,    stb_d;
    logic        exp_q,    exp_d;
    logic        wr_en;
    logic [31:0] wr_mask;

    bit_prescaler #(.CW(16)) u_presc (
        .ref_clk (ref_clk),
        .rst_b   (rst_b),
        .tk      (tk)
    );

    assign tk.divider = div_q;
    assign wr_en      = wb_cyc_i & wb_stb_i & wb_we_i & ~ack_q;
    assign wr_mask    = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                         {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

    // Merge write data under byte lanes
    function automatic logic [31:0] merge(input logic [31:0] old);
        merge = (old & ~wr_mask) | (wb_dat_i & wr_mask);
    endfunction

    // Register writes, read mux and single-cycle ack
    always_comb begin
        logic [31:0] m;
        m      = '0;
        div_d  = div_q;
        txl_d  = txl_q;
        rxl_d  = rxl_q;
        pre_d  = pre_q;
        slo_d  = slo_q;
        shi_d  = shi_q;
        rep_d  = rep_q;
        std_d  = std_q;
        go_tx  = 1'b0;
        go_rx  = 1'b0;
        ack_d  = wb_cyc_i & wb_stb_i & ~ack_q;
        rdat_d = '0;
        if (wr_en) begin
            unique case (wb_adr_i)
                `OFS_BIT_CLOCK_PRESCALE: begin
                    m     = merge({16'h0000, div_q});
                    div_d = m[`PRESCALE_MSB:0];
                end
                `OFS_RADIO_WARMUP_LEAD: begin
                    m     = merge({4'h0, txl_q, 4'h0, rxl_q});
                    txl_d = m[`TX_LEAD_MSB:`TX_LEAD_LSB];
                    rxl_d = m[`RX_LEAD_MSB:`RX_LEAD_LSB];
                end
                `OFS_PREAMBLE_PATTERN: pre_d = merge(pre_q);
                `OFS_SYNC_WORD_LOW:    slo_d = merge(slo_q);
                `OFS_SYNC_WORD_HIGH:   shi_d = merge(shi_q);
                `OFS_FRAME_CONTROL: begin
                    m     = merge({25'h0, std_q, 2'b00, rep_q});
                    rep_d = m[`CTRL_REPEAT_MSB:`CTRL_REPEAT_LSB];
                    std_d = m[`CTRL_STD_MODE];
                    go_tx = m[`CTRL_TX_START];
                    go_rx = m[`CTRL_RX_START];
                end
                default: ;
            endcase
        end
        if (wb_cyc_i & wb_stb_i & ~wb_we_i & ~ack_q) begin
            unique case (wb_adr_i)
                `OFS_RADIO_WARMUP_LEAD:
                    rdat_d = {4'h0, txl_q, 4'h0, rxl_q};
                `OFS_PREAMBLE_PATTERN: rdat_d = pre_q;
                `OFS_SYNC_WORD_LOW:    rdat_d = slo_q;
                `OFS_SYNC_WORD_HIGH:   rdat_d = shi_q;
                `OFS_FRAME_CONTROL:
                    rdat_d = {25'h0, std_q, 2'b00, rep_q};
                `OFS_FRAME_STATUS:
                    rdat_d = {27'h0, st_q, rxw_q, txw_q};
                default: rdat_d = '0;
            endcase
        end
    end

    // Register bank flops
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            div_q  <= `RST_PRESCALE;
            txl_q  <= `RST_WARMUP;
            rxl_q  <= `RST_WARMUP;
            pre_q  <= `RST_WORD;
            slo_q  <= `RST_WORD;
            shi_q  <= `RST_WORD;
            rep_q  <= `RST_REPEAT;
            std_q  <= 1'b0;
            ack_q  <= 1'b0;
            rdat_q <= `RST_WORD;
        end else begin
            div_q  <= div_d;
            txl_q  <= txl_d;
            rxl_q  <= rxl_d;
            pre_q  <= pre_d;
            slo_q  <= slo_d;
            shi_q  <= shi_d;
            rep_q  <= rep_d;
            std_q  <= std_d;
            ack_q  <= ack_d;
            rdat_q <= rdat_d;
        end
    end

    // Frame prefix sequencer
    always_comb begin
        st_d   = st_q;
        lcnt_d = lcnt_q;
        idx_d  = idx_q;
        rcnt_d = rcnt_q;
        txw_d  = txw_q;
        rxw_d  = rxw_q;
        bit_d  = bit_q;
        stb_d  = 1'b0;
        exp_d  = 1'b0;
        unique case (st_q)
            ST_IDLE: begin
                lcnt_d = '0;
                idx_d  = '0;
                rcnt_d = '0;
                if (go_tx) begin
                    txw_d = 1'b1;
                    if (txl_q != '0)
                        st_d = ST_TX_LEAD;
                    else if (rep_q != '0)
                        st_d = ST_TX_PRE;
                    else
                        st_d = ST_TX_SYNC_LO;
                end else if (go_rx) begin
                    rxw_d = 1'b1;
                    if (rxl_q != '0) begin
                        st_d = ST_RX_LEAD;
                    end else begin
                        exp_d = 1'b1;
                        rxw_d = 1'b0;
                    end
                end
            end
            ST_TX_LEAD: if (tk.tick) begin
                lcnt_d = lcnt_q + 1'b1;
                if (lcnt_q + 1'b1 == txl_q)
                    st_d = (rep_q != '0) ? ST_TX_PRE : ST_TX_SYNC_LO;
            end
            ST_TX_PRE: if (tk.tick) begin
                bit_d = pre_q[idx_q];
                stb_d = 1'b1;
                idx_d = idx_q + 1'b1;
                if (idx_q == `WORD_LAST_BIT) begin
                    rcnt_d = rcnt_q + 1'b1;
                    if (rcnt_q + 1'b1 == rep_q)
                        st_d = ST_TX_SYNC_LO;
                end
            end
            ST_TX_SYNC_LO: if (tk.tick) begin
                bit_d = slo_q[idx_q];
                stb_d = 1'b1;
                idx_d = idx_q + 1'b1;
                if (idx_q == `WORD_LAST_BIT)
                    st_d = ST_TX_SYNC_HI;
            end
            ST_TX_SYNC_HI: if (tk.tick) begin
                bit_d = shi_q[idx_q];
                stb_d = 1'b1;
                idx_d = idx_q + 1'b1;
                if (idx_q == (std_q ? `STD_HIGH_LAST : `WORD_LAST_BIT)) begin
                    st_d  = ST_IDLE;
                    txw_d = 1'b0;
                end
            end
            ST_RX_LEAD: if (tk.tick) begin
                lcnt_d = lcnt_q + 1'b1;
                if (lcnt_q + 1'b1 == rxl_q) begin
                    exp_d = 1'b1;
                    rxw_d = 1'b0;
                    st_d  = ST_IDLE;
                end
            end
            default: st_d = ST_IDLE;
        endcase
    end

    // Sequencer flops
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            st_q   <= ST_IDLE;
            lcnt_q <= '0;
            idx_q  <= '0;
            rcnt_q <= '0;
            txw_q  <= 1'b0;
            rxw_q  <= 1'b0;
            bit_q  <= 1'b0;
            stb_q  <= 1'b0;
            exp_q  <= 1'b0;
        end else begin
            st_q   <= st_d;
            lcnt_q <= lcnt_d;
            idx_q  <= idx_d;
            rcnt_q <= rcnt_d;
            txw_q  <= txw_d;
            rxw_q  <= rxw_d;
            bit_q  <= bit_d;
            stb_q  <= stb_d;
            exp_q  <= exp_d;
        end
    end

    // Outputs straight from flops
    assign wb_dat_o    = rdat_q;
    assign wb_ack_o    = ack_q;
    assign tx_warmup   = txw_q;
    assign tx_bit      = bit_q;
    assign tx_bit_stb  = stb_q;
    assign rx_warmup   = rxw_q;
    assign rx_expect   = exp_q;
    assign bit_divider = div_q;
endmodule

// File: sim/frame_prefix_chk.sv
`timescale 1ns/100ps
`include "frame_prefix_regs.svh"
module frame_prefix_chk (
    // Clock and reset
    input wire logic        ref_clk,
    input wire logic        rst_b,
    // Register bus
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [11:0] wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    // Modem side
    input wire logic        tx_warmup,
    input wire logic        tx_bit,
    input wire logic        tx_bit_stb,
    input wire logic        rx_warmup,
    input wire logic        rx_expect,
    input wire frame_prefix_pkg::prescale_t bit_divider
);
    import frame_prefix_pkg::*;
    logic        req;
    logic        wr_ctl;
    logic        idle;
    logic [15:0] gap_q, gap_d;
    logic        seen_q, seen_d;
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_b);
    // Request decode
    assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr_ctl = req && wb_we_i && wb_sel_i[0]
        && wb_adr_i == `OFS_FRAME_CONTROL;
    assign idle = !tx_warmup && !rx_warmup;
    // Cycles since the previous bit strobe of the same frame
    always_comb begin
        gap_d = tx_bit_stb ? 16'h0000 : gap_q + 16'h0001;
        seen_d = tx_warmup && (seen_q || tx_bit_stb);
    end
    always_ff @(posedge ref_clk) begin
        gap_q <= rst_b ? gap_d : 16'h0000;
        seen_q <= rst_b && seen_d;
    end
    property p_div_rd;
        req && !wb_we_i && wb_adr_i == `OFS_BIT_CLOCK_PRESCALE
            |=> wb_dat_o == 32'h0000_0000;
    endproperty
    a_div_rd: assert property (p_div_rd)
        else $error("Prescale read not zero");
    property p_rsvd;
        req && !wb_we_i && wb_adr_i == `OFS_RADIO_WARMUP_LEAD
            |=> (wb_dat_o & 32'hF000_F000) == 32'h0000_0000;
    endproperty
    a_rsvd: assert property (p_rsvd)
        else $error("Reserved warmup bits set");
    property p_gap;
        tx_bit_stb && seen_q |-> gap_q == bit_divider;
    endproperty
    a_gap: assert property (p_gap)
        else $error("Bit strobe spacing wrong");
    property p_stb_frame;
        tx_bit_stb |-> $past(tx_warmup);
    endproperty
    a_stb_frame: assert property (p_stb_frame)
        else $error("Bit strobe outside frame");
    property p_tx_start;
        wr_ctl && wb_dat_i[4] && idle |=> tx_warmup;
    endproperty
    a_tx_start: assert property (p_tx_start)
        else $error("Tx warmup did not start");
    property p_rx_start;
        wr_ctl && wb_dat_i[5] && !wb_dat_i[4] && idle
            |=> rx_warmup || rx_expect;
    endproperty
    a_rx_start: assert property (p_rx_start)
        else $error("Rx warmup did not start");
    property p_tx_end;
        $fell(tx_warmup) |-> tx_bit_stb;
    endproperty
    a_tx_end: assert property (p_tx_end)
        else $error("Tx warmup fell without last bit");
    property p_rx_end;
        $fell(rx_warmup) |-> rx_expect;
    endproperty
    a_rx_end: assert property (p_rx_end)
        else $error("Rx warmup fell without expect");
    property p_rx_pulse;
        rx_expect |-> !rx_warmup ##1 !rx_expect;
    endproperty
    a_rx_pulse: assert property (p_rx_pulse)
        else $error("Rx expect not a single pulse");
    c_tx: cover property ($fell(tx_warmup));
    c_rx: cover property (rx_expect);
    c_div: cover property (req && wb_adr_i == `OFS_BIT_CLOCK_PRESCALE);
endmodule
bind frame_prefix_top frame_prefix_chk i_chk (.*);

// File: sim/modem_model.sv
`timescale 1ns/100ps
module modem_model (
    // Clock
    input wire logic ref_clk,
    // Transmit chain
    input wire logic tx_warmup,
    input wire logic tx_bit,
    input wire logic tx_bit_stb
);
    logic bits[$];
    logic warm_q = 1'b0;
    int   lead_cyc = 0;
    int   first_cyc = -1;
    // Collect on-air bits and time the first one after warmup
    always @(posedge ref_clk) begin
        warm_q <= tx_warmup;
        if (tx_warmup && !warm_q) begin
            bits.delete();
            lead_cyc = 0;
            first_cyc = -1;
        end else if (tx_warmup) begin
            lead_cyc++;
        end
        if (tx_bit_stb === 1'b1) begin
            if (first_cyc < 0)
                first_cyc = lead_cyc;
            bits.push_back(tx_bit);
        end
    end
endmodule

// File: sim/frame_prefix_top_tb_top.sv
`timescale 1ns/100ps
`include "frame_prefix_regs.svh"
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin \
    bad_count++; $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module frame_prefix_top_tb_top;
    import frame_prefix_pkg::*;
    logic        ref_clk = 1'b0;
    logic        rst_b = 1'b0;
    logic        wb_cyc_i = 1'b0;
    logic        wb_stb_i = 1'b0;
    logic        wb_we_i = 1'b0;
    logic [11:0] wb_adr_i = 12'h000;
    logic [3:0]  wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0000_0000;
    logic [31:0] wb_dat_o, rd;
    logic        wb_ack_o, tx_warmup, tx_bit, tx_bit_stb;
    logic        rx_warmup, rx_expect;
    prescale_t   bit_divider;
    int          bad_count = 0;
    int          comparisons = 0;
    int          seed = 71459;
    int          rx_cnt = 0;
    int          rx_got = -1;
    frame_prefix_top i_dut (.*);
    modem_model i_modem (.*);
    // 40 MHz clock
    initial begin
        forever #12.5 ref_clk = ~ref_clk;
    end
    // Receive lead timing seen at the modem
    always @(posedge ref_clk) begin
        if (rx_expect === 1'b1)
            rx_got = rx_cnt;
        rx_cnt = (rx_warmup === 1'b1) ? rx_cnt + 1 : 0;
    end
    task automatic wb_io(input logic w, input logic [11:0] a,
                         input logic [31:0] d);
        {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b11, w};
        wb_adr_i <= a;
        wb_sel_i <= 4'hF;
        wb_dat_i <= d;
        // Hold the request until ack is seen at a rising edge
        do @(posedge ref_clk); while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        {wb_cyc_i, wb_stb_i} <= 2'b00;
        @(posedge ref_clk);
    endtask
    task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
        wb_io(1'b0, a, 32'h0000_0000);
        `CHK(rd, e)
    endtask
    function automatic logic exp_bit(int j, int r, logic [31:0] p,
                                     logic [31:0] lo, logic [31:0] hi);
        if (j < 32 * r)
            return p[j % 32];
        j = j - 32 * r;
        return (j < 32) ? lo[j] : hi[j - 32];
    endfunction
    function automatic logic in_win(int c, int l, int n);
        return (c >= 0) && (c + n + 1 >= l * n) && (c <= l * n + n + 1);
    endfunction
    task automatic finish_test;
        $display("Comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // Watchdog
    initial begin
        repeat (60000) @(posedge ref_clk);
        bad_count++;
        finish_test;
    end
    initial begin
        logic [31:0] p, lo, hi, w;
        int r, l, n, k;
        repeat (5) @(posedge ref_clk);
        rst_b <= 1'b1;
        @(posedge ref_clk);
        rd_chk(`OFS_BIT_CLOCK_PRESCALE, 32'h0000_0000);
        rd_chk(`OFS_SYNC_WORD_LOW, 32'h0000_0000);
        w = $random(seed);
        wb_io(1'b1, `OFS_RADIO_WARMUP_LEAD, w);
        rd_chk(`OFS_RADIO_WARMUP_LEAD, w & 32'h0FFF_0FFF);
        wb_io(1'b1, 12'h200, w);
        rd_chk(12'h200, 32'h0000_0000);
        // Random frames, repeat counts 0 and 15 among them
        for (int i = 0; i < 6; i++) begin
            r = (i == 1) ? 15 : (i == 0) ? 0 : {$random(seed)} % 3;
            // Last frame at 40 MHz over 160, the 250 kHz bit rate
            n = (i == 5) ? 160 : {$random(seed)} % 4 + 1;
            l = {$random(seed)} % 6;
            p = $random(seed);
            lo = $random(seed);
            hi = $random(seed);
            wb_io(1'b1, `OFS_BIT_CLOCK_PRESCALE, {w[31:16], 16'(n - 1)});
            `CHK(bit_divider, prescale_t'(n - 1))
            rd_chk(`OFS_BIT_CLOCK_PRESCALE, 32'h0000_0000);
            wb_io(1'b1, `OFS_RADIO_WARMUP_LEAD, {2{4'hF, 12'(l)}});
            wb_io(1'b1, `OFS_PREAMBLE_PATTERN, p);
            rd_chk(`OFS_PREAMBLE_PATTERN, p);
            wb_io(1'b1, `OFS_SYNC_WORD_LOW, lo);
            rd_chk(`OFS_SYNC_WORD_LOW, lo);
            wb_io(1'b1, `OFS_SYNC_WORD_HIGH, hi);
            wb_io(1'b1, `OFS_FRAME_CONTROL, {25'h0, i[0], 2'b01, 4'(r)});
            k = 0;
            while (tx_warmup === 1'b1 && k < 25000) begin
                @(posedge ref_clk);
                k++;
            end
            // Let the modem take the last strobe first
            @(posedge ref_clk);
            `CHK(k < 25000, 1'b1)
            `CHK(in_win(i_modem.first_cyc, l, n), 1'b1)
            `CHK(i_modem.bits.size(), 32 * r + (i[0] ? 40 : 64))
            for (int j = 0; j < i_modem.bits.size(); j++)
                `CHK(i_modem.bits[j], exp_bit(j, r, p, lo, hi))
            rx_got = -1;
            wb_io(1'b1, `OFS_FRAME_CONTROL, 32'h0000_0020);
            for (k = 0; rx_got < 0 && k < 9000; k++)
                @(posedge ref_clk);
            `CHK(in_win(rx_got, l, n), 1'b1)
        end
        finish_test;
    end
endmodule
